/* File: rtl/usart_defines.svh */
`ifndef USART_DEFINES_SVH
`define USART_DEFINES_SVH

// ==========================================
// Port select
`define PORT_DATA   1'b0
`define PORT_CTRL   1'b1

// ==========================================
// Mode word fields
`define MD_BAUD     1:0
`define MD_LEN      3:2
`define MD_PEN      4
`define MD_EP       5
`define MD_STOP     7:6
`define MD_ESD      6
`define MD_SCS      7
`define BAUD_SYNC   2'h0
`define BAUD_X1     2'h1
`define BAUD_X16    2'h2
`define BAUD_X64    2'h3
`define BT_X1       7'h01
`define BT_X16      7'h10
`define BT_X64      7'h40
`define STOP_TWO    2'h3
`define LEN_BASE    4'h5
`define MODE_RST    8'h00

// ==========================================
// Command word fields
`define CMD_TXEN    0
`define CMD_DTR     1
`define CMD_RXE     2
`define CMD_SBRK    3
`define CMD_ER      4
`define CMD_RTS     5
`define CMD_IR      6
`define CMD_EH      7
`define CMD_RST     8'h00

// ==========================================
// Status word fields
`define ST_TRANSMITTER_CAN_ACCEPT    0
`define ST_RECEIVE_CHAR_WAITING    1
`define ST_TXE      2
`define ST_PE       3
`define ST_OE       4
`define ST_FE       5
`define ST_CHAR_SYNC_ACHIEVED   6
`define ST_DSR      7

`endif

/* File: rtl/usart_pkg.sv */
package usart_pkg;

    typedef enum logic [3:0] {
        ph_mode  = 4'h1,
        ph_sync1 = 4'h2,
        ph_sync2 = 4'h4,
        ph_cmd   = 4'h8
    } phase_t;

    typedef enum logic [3:0] {
        rx_idle  = 4'h1,
        rx_start = 4'h2,
        rx_bits  = 4'h4,
        rx_hunt  = 4'h8
    } rx_state_t;

endpackage

/* File: rtl/board_serial_usart_interface.sv */
`timescale 1ns/100ps
`default_nettype none
`include "usart_defines.svh"

module board_serial_usart_interface
    import usart_pkg::*;
#(
    parameter int CLK_DIV = 16
) (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    input  wire logic       rxd,
    output logic            txd,
    input  wire logic       dsr_n,
    input  wire logic       ext_sync,
    output logic            dtr_n,
    output logic            rts_n,
    output logic            transmitter_can_accept,
    output logic            receive_char_waiting,
    output logic            transmit_register_vacant
);

    // ==========================================
    // Decoding helpers
    function automatic logic [6:0] bit_ticks(input logic [1:0] b);
        logic [6:0] t;
        t = `BT_X1;
        unique case (b)
            `BAUD_X16: t = `BT_X16;
            `BAUD_X64: t = `BT_X64;
            default:   t = `BT_X1;
        endcase
        return t;
    endfunction

    function automatic logic [7:0] len_mask(input logic [3:0] n);
        return 8'(9'h1ff >> (4'h9 - n));
    endfunction

    // ==========================================
    // Declarations
    phase_t      ph_r;
    rx_state_t   rx_st_r;
    logic [7:0]  mode_r;
    logic [7:0]  sync1_r;
    logic [7:0]  sync2_r;
    logic [7:0]  cmd_r;
    logic        init_r;
    logic [15:0] div_r;
    logic [7:0]  tx_buf_r;
    logic        tx_full_r;
    logic [11:0] tx_sh_r;
    logic [3:0]  tx_left_r;
    logic [6:0]  tx_cnt_r;
    logic        txd_r;
    logic [7:0]  rx_buf_r;
    logic        rx_full_r;
    logic        pe_r;
    logic        oe_r;
    logic        fe_r;
    logic        char_sync_achieved_r;
    logic [6:0]  rx_cnt_r;
    logic [3:0]  rx_idx_r;
    logic [11:0] rx_sh_r;
    logic [17:0] hunt_r;
    logic [7:0]  rdata_r;
    logic [7:0]  status;

    // ==========================================
    // Host port decode
    logic wr_ctl;
    logic wr_dat;
    logic rd_dat;
    logic cmd_wr;
    logic ireset;
    logic er_clr;
    assign wr_ctl = wr && addr == `PORT_CTRL;
    assign wr_dat = wr && addr == `PORT_DATA && init_r;
    assign rd_dat = rd && addr == `PORT_DATA;
    assign cmd_wr = wr_ctl && ph_r == ph_cmd;
    assign ireset = cmd_wr && wdata[`CMD_IR];
    assign er_clr = cmd_wr && wdata[`CMD_ER];

    // ==========================================
    // Format decode
    logic       sync_md;
    logic       pen;
    logic       ep;
    logic       stop2;
    logic [3:0] nbits;
    logic [3:0] wbits;
    logic [7:0] msk;
    logic [6:0] bt;
    assign sync_md = mode_r[`MD_BAUD] == `BAUD_SYNC;
    assign pen     = mode_r[`MD_PEN];
    assign ep      = mode_r[`MD_EP];
    assign stop2   = mode_r[`MD_STOP] == `STOP_TWO;
    assign nbits   = 4'(mode_r[`MD_LEN]) + `LEN_BASE;
    assign wbits   = nbits + 4'(pen);
    assign msk     = len_mask(nbits);
    assign bt      = sync_md ? `BT_X1 : bit_ticks(mode_r[`MD_BAUD]);

    // ==========================================
    // Baud tick
    logic tick;
    assign tick = div_r == 16'(CLK_DIV - 1);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            div_r <= '0;
        end else begin
            div_r <= tick ? '0 : div_r + 16'h1;
        end
    end

    // ==========================================
    // Initialization sequence
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ph_r    <= ph_mode;
            mode_r  <= `MODE_RST;
            sync1_r <= 8'h00;
            sync2_r <= 8'h00;
            cmd_r   <= `CMD_RST;
            init_r  <= 1'b0;
        end else if (wr_ctl) begin
            unique case (ph_r)
                ph_mode: begin
                    mode_r <= wdata;
                    ph_r   <= wdata[`MD_BAUD] == `BAUD_SYNC ? ph_sync1 : ph_cmd;
                end
                ph_sync1: begin
                    sync1_r <= wdata;
                    ph_r    <= mode_r[`MD_SCS] ? ph_cmd : ph_sync2;
                end
                ph_sync2: begin
                    sync2_r <= wdata;
                    ph_r    <= ph_cmd;
                end
                ph_cmd: begin
                    if (wdata[`CMD_IR]) begin
                        ph_r   <= ph_mode;
                        cmd_r  <= `CMD_RST;
                        init_r <= 1'b0;
                    end else begin
                        cmd_r  <= wdata & ~8'((1 << `CMD_ER) | (1 << `CMD_EH));
                        init_r <= 1'b1;
                    end
                end
            endcase
        end
    end

    // ==========================================
    // Transmitter
    logic [7:0]  tx_d;
    logic        tx_par;
    logic [11:0] frame;
    logic [11:0] tx_frame;
    logic [3:0]  tx_len;
    logic        tx_load;
    assign tx_d     = tx_buf_r & msk;
    assign tx_par   = ^tx_d ^ ~ep;
    assign frame    = 12'(tx_d) | (12'(pen & tx_par) << nbits) | (12'hfff << wbits);
    assign tx_frame = sync_md ? frame : {frame[10:0], 1'b0};
    assign tx_len   = wbits + (sync_md ? 4'h0 : (stop2 ? 4'h3 : 4'h2));
    assign tx_load  = init_r && cmd_r[`CMD_TXEN] && tx_full_r && tx_left_r == 4'h0;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tx_buf_r  <= 8'h00;
            tx_full_r <= 1'b0;
        end else if (ireset) begin
            tx_full_r <= 1'b0;
        end else begin
            if (wr_dat) begin
                tx_buf_r <= wdata;
            end
            tx_full_r <= wr_dat || (tx_full_r && !tx_load);
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tx_sh_r   <= '1;
            tx_left_r <= 4'h0;
            tx_cnt_r  <= 7'h00;
        end else if (ireset) begin
            tx_left_r <= 4'h0;
            tx_cnt_r  <= 7'h00;
        end else if (tx_load) begin
            tx_sh_r   <= tx_frame;
            tx_left_r <= tx_len;
            tx_cnt_r  <= 7'h00;
        end else if (tick && tx_left_r != 4'h0) begin
            if (tx_cnt_r == bt - 7'h1) begin
                tx_cnt_r  <= 7'h00;
                tx_sh_r   <= {1'b1, tx_sh_r[11:1]};
                tx_left_r <= tx_left_r - 4'h1;
            end else begin
                tx_cnt_r <= tx_cnt_r + 7'h1;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            txd_r <= 1'b1;
        end else begin
            txd_r <= cmd_r[`CMD_SBRK] ? 1'b0 : (tx_left_r != 4'h0 ? tx_sh_r[0] : 1'b1);
        end
    end

    // ==========================================
    // Receiver
    logic [11:0] rx_word;
    logic [3:0]  rx_len;
    logic        rx_done;
    logic        rx_got;
    logic [7:0]  rx_data;
    logic        rx_perr;
    logic        rx_ferr;
    logic [17:0] win;
    logic [7:0]  c1;
    logic [7:0]  c2;
    logic        hit;
    assign rx_word = rx_sh_r | (12'(rxd) << rx_idx_r);
    assign rx_len  = wbits + (sync_md ? 4'h0 : 4'h1);
    assign rx_done = rx_st_r == rx_bits && tick && rx_cnt_r == bt - 7'h1
                     && rx_idx_r == rx_len - 4'h1;
    assign rx_got  = rx_done && cmd_r[`CMD_RXE];
    assign rx_data = rx_word[7:0] & msk;
    assign rx_perr = pen && (^rx_data ^ rx_word[nbits] ^ ~ep);
    assign rx_ferr = !sync_md && !rx_word[wbits];
    assign win     = {rxd, hunt_r[17:1]};
    assign c2      = 8'(win >> (5'h12 - 5'(wbits))) & msk;
    assign c1      = 8'(win >> (5'h12 - 5'(wbits) - 5'(wbits))) & msk;
    assign hit     = mode_r[`MD_SCS] ? c2 == (sync1_r & msk)
                     : (c1 == (sync1_r & msk) && c2 == (sync2_r & msk));

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rx_st_r  <= rx_idle;
            rx_cnt_r <= 7'h00;
            rx_idx_r <= 4'h0;
            rx_sh_r  <= 12'h000;
            hunt_r   <= 18'h00000;
        end else if (ireset) begin
            rx_st_r <= rx_idle;
        end else if (cmd_wr && sync_md && wdata[`CMD_EH]) begin
            rx_st_r <= rx_hunt;
        end else if (tick) begin
            unique case (rx_st_r)
                rx_idle: begin
                    if (init_r && cmd_r[`CMD_RXE] && !sync_md && !rxd) begin
                        rx_st_r  <= bt == `BT_X1 ? rx_bits : rx_start;
                        rx_cnt_r <= 7'h00;
                        rx_idx_r <= 4'h0;
                        rx_sh_r  <= 12'h000;
                    end
                end
                rx_start: begin
                    if (rx_cnt_r == (bt >> 1)) begin
                        rx_st_r  <= rxd ? rx_idle : rx_bits;
                        rx_cnt_r <= 7'h00;
                    end else begin
                        rx_cnt_r <= rx_cnt_r + 7'h1;
                    end
                end
                rx_bits: begin
                    if (rx_cnt_r == bt - 7'h1) begin
                        rx_cnt_r <= 7'h00;
                        if (rx_done) begin
                            rx_st_r  <= sync_md ? rx_bits : rx_idle;
                            rx_idx_r <= 4'h0;
                            rx_sh_r  <= 12'h000;
                        end else begin
                            rx_idx_r <= rx_idx_r + 4'h1;
                            rx_sh_r  <= rx_word;
                        end
                    end else begin
                        rx_cnt_r <= rx_cnt_r + 7'h1;
                    end
                end
                rx_hunt: begin
                    hunt_r <= win;
                    if (mode_r[`MD_ESD] ? ext_sync : hit) begin
                        rx_st_r  <= rx_bits;
                        rx_cnt_r <= 7'h00;
                        rx_idx_r <= 4'h0;
                        rx_sh_r  <= 12'h000;
                    end
                end
            endcase
        end
    end

    // ==========================================
    // Receive buffer and error flags
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rx_buf_r  <= 8'h00;
            rx_full_r <= 1'b0;
            pe_r      <= 1'b0;
            oe_r      <= 1'b0;
            fe_r      <= 1'b0;
        end else if (ireset) begin
            rx_full_r <= 1'b0;
            pe_r      <= 1'b0;
            oe_r      <= 1'b0;
            fe_r      <= 1'b0;
        end else begin
            if (rx_got) begin
                rx_buf_r <= rx_data;
            end
            rx_full_r <= rx_got || (rx_full_r && !rd_dat);
            pe_r <= (rx_got && rx_perr) || (pe_r && !er_clr);
            oe_r <= (rx_got && rx_full_r && !rd_dat) || (oe_r && !er_clr);
            fe_r <= (rx_got && rx_ferr) || (fe_r && !er_clr);
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            char_sync_achieved_r <= 1'b0;
        end else if (ireset || (cmd_wr && wdata[`CMD_EH])) begin
            char_sync_achieved_r <= 1'b0;
        end else if (tick && rx_st_r == rx_hunt && !mode_r[`MD_ESD] && hit) begin
            char_sync_achieved_r <= 1'b1;
        end
    end

    // ==========================================
    // Status and read port
    always_comb begin
        status               = 8'h00;
        status[`ST_TRANSMITTER_CAN_ACCEPT]    = init_r && !tx_full_r;
        status[`ST_RECEIVE_CHAR_WAITING]    = rx_full_r;
        status[`ST_TXE]      = !tx_full_r && tx_left_r == 4'h0;
        status[`ST_PE]       = pe_r;
        status[`ST_OE]       = oe_r;
        status[`ST_FE]       = fe_r;
        status[`ST_CHAR_SYNC_ACHIEVED]   = char_sync_achieved_r;
        status[`ST_DSR]      = !dsr_n;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdata_r <= 8'h00;
        end else if (rd) begin
            rdata_r <= addr == `PORT_CTRL ? status : rx_buf_r;
        end else begin
            rdata_r <= 8'h00;
        end
    end

    // ==========================================
    // Outputs
    assign rdata                    = rdata_r;
    assign txd                      = txd_r;
    assign dtr_n                    = !cmd_r[`CMD_DTR];
    assign rts_n                    = !cmd_r[`CMD_RTS];
    assign transmitter_can_accept   = status[`ST_TRANSMITTER_CAN_ACCEPT];
    assign receive_char_waiting     = status[`ST_RECEIVE_CHAR_WAITING];
    assign transmit_register_vacant = status[`ST_TXE];

endmodule // board_serial_usart_interface
`default_nettype wire

/* File: testbench/board_serial_usart_interface_monitor.sv */
`timescale 1ns/100ps
`default_nettype none

module board_serial_usart_interface_monitor
    import usart_pkg::*;
#(
    parameter int CLK_DIV = 16
) (
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic       addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic       rxd,
    input wire logic       txd,
    input wire logic       dsr_n,
    input wire logic       ext_sync,
    input wire logic       dtr_n,
    input wire logic       rts_n,
    input wire logic       transmitter_can_accept,
    input wire logic       receive_char_waiting,
    input wire logic       transmit_register_vacant
);
    // =====
    // Control write phase tracker
    logic [1:0] ph_r;
    logic       single_r;
    logic       init_r;
    wire        cw = wr && addr;
    wire        cmd_wr = cw && ph_r == 2'h3;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ph_r <= 2'h0;
            single_r <= 1'b0;
            init_r <= 1'b0;
        end else if (cw) begin
            case (ph_r)
                2'h0: begin
                    ph_r <= (wdata[1:0] == 2'h0) ? 2'h1 : 2'h3;
                    single_r <= wdata[7];
                end
                2'h1: ph_r <= single_r ? 2'h3 : 2'h2;
                2'h2: ph_r <= 2'h3;
                default: begin
                    ph_r <= wdata[6] ? 2'h0 : 2'h3;
                    init_r <= !wdata[6];
                end
            endcase
        end
    end

    // =====
    // Assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_rdata_idle_zero: assert property (!rd |=> rdata == 8'h00)
        else $error("read data not zero outside read answer");
    a_status_snapshot: assert property (rd && addr |=>
        rdata[2:0] == $past({transmit_register_vacant, receive_char_waiting,
        transmitter_can_accept}) && rdata[7] == !$past(dsr_n))
        else $error("status byte does not match status outputs");
    a_no_early_ready: assert property (!init_r |-> !transmitter_can_accept)
        else $error("transmit ready before initialization done");
    a_mode_not_ready: assert property (cw && ph_r == 2'h0 |=> !transmitter_can_accept)
        else $error("mode write made transmitter ready");
    a_cmd_gives_ready: assert property (cmd_wr && !init_r && wdata[0] && !wdata[6]
        |=> transmitter_can_accept)
        else $error("first command did not enable transmitter");
    a_modem_lines: assert property (cmd_wr |=>
        dtr_n == !($past(wdata[1]) && !$past(wdata[6]))
        && rts_n == !($past(wdata[5]) && !$past(wdata[6])))
        else $error("modem outputs do not follow command");
    a_modem_hold: assert property (!cmd_wr |=> $stable(dtr_n) && $stable(rts_n))
        else $error("modem outputs changed without command");
    a_reset_cmd_clears: assert property (cmd_wr && wdata[6]
        |=> !transmitter_can_accept && !receive_char_waiting)
        else $error("internal reset did not clear ready flags");
    a_data_read_clears: assert property (rd && !addr |=> !receive_char_waiting)
        else $error("data read left receive flag set");

    c_reset_cmd: cover property (cmd_wr && wdata[6]);
    c_status_read: cover property (rd && addr);
    c_char_read: cover property (rd && !addr && receive_char_waiting);
endmodule // board_serial_usart_interface_monitor

bind board_serial_usart_interface board_serial_usart_interface_monitor #(.CLK_DIV(CLK_DIV))
    u_mon (.clk_sys(clk_sys), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .rxd(rxd), .txd(txd), .dsr_n(dsr_n), .ext_sync(ext_sync),
    .dtr_n(dtr_n), .rts_n(rts_n), .transmitter_can_accept(transmitter_can_accept),
    .receive_char_waiting(receive_char_waiting),
    .transmit_register_vacant(transmit_register_vacant));

`default_nettype wire

/* File: testbench/serial_terminal_model.sv */
`timescale 1ns/100ps
`default_nettype none

module serial_terminal_model #(
    parameter int BIT_CLKS = 32
) (
    input  wire logic clk_sys,
    input  wire logic txd,
    output logic      rxd
);
    logic [7:0] got;
    int         n_got = 0;

    initial rxd = 1'b1;

    // =====
    // Line driver, bits LSB first, idle mark after
    task automatic send(input logic [11:0] b, input int n, input int len);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_sys);
            rxd <= b[i];
            repeat (len - 1) @(posedge clk_sys);
        end
        @(posedge clk_sys);
        rxd <= 1'b1;
    endtask

    // =====
    // Frame capture, sampled mid-bit
    always begin
        @(negedge txd);
        repeat (BIT_CLKS / 2) @(posedge clk_sys);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CLKS) @(posedge clk_sys);
            got[i] = txd;
        end
        repeat (BIT_CLKS) @(posedge clk_sys);
        n_got = n_got + 1;
    end
endmodule // serial_terminal_model

`default_nettype wire

/* File: testbench/board_serial_usart_interface_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none

module board_serial_usart_interface_tb_top import usart_pkg::*;;
    localparam int DIV = 2;
    localparam int BITC = 16 * DIV;

    logic       clk_sys, rst, addr, wr, rd, dsr_n, ext_sync;
    logic [7:0] wdata, rdata;
    logic       rxd, txd, dtr_n, rts_n;
    logic       transmitter_can_accept, receive_char_waiting, transmit_register_vacant;
    int         n_errors, samples_checked;
    int         cycles = 0;

    board_serial_usart_interface #(.CLK_DIV(DIV)) dut (.clk_sys(clk_sys), .rst(rst),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rxd(rxd), .txd(txd),
        .dsr_n(dsr_n), .ext_sync(ext_sync), .dtr_n(dtr_n), .rts_n(rts_n),
        .transmitter_can_accept(transmitter_can_accept),
        .receive_char_waiting(receive_char_waiting),
        .transmit_register_vacant(transmit_register_vacant));
    serial_terminal_model #(.BIT_CLKS(BITC)) term (.clk_sys(clk_sys), .txd(txd), .rxd(rxd));

    // =====
    // Bus and compare helpers
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bw(input logic a, input logic [7:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask
    task automatic br(input logic a, output logic [7:0] d);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic wait_st(input int b);
        logic [7:0] s;
        for (int i = 0; i < 300; i++) begin
            br(1'b1, s);
            if (s[b] === 1'b1) break;
        end
    endtask
    task automatic init(input logic [7:0] m, input logic [7:0] sy, input logic [7:0] c);
        logic [7:0] s;
        repeat (3) bw(1'b1, 8'h00);
        bw(1'b1, 8'h40);
        bw(1'b1, m);
        if (m[1:0] == 2'h0) bw(1'b1, sy);
        br(1'b1, s);
        check(s & 8'h01, 8'h00);
        bw(1'b1, c);
        #1 check({7'h0, transmitter_can_accept}, 8'h01);
    endtask

    // =====
    // Scenarios
    task automatic t_reset();
        logic [7:0] s;
        check({2'h0, txd, dtr_n, rts_n, transmitter_can_accept, receive_char_waiting,
            transmit_register_vacant}, 8'h39);
        bw(1'b0, 8'hff);
        br(1'b1, s);
        check(s, 8'h84);
        @(posedge clk_sys);
        dsr_n <= 1'b1;
        br(1'b1, s);
        check(s, 8'h04);
        dsr_n <= 1'b0;
    endtask
    task automatic t_tx();
        logic [7:0] s;
        init(8'h4e, 8'h00, 8'h27);
        check({6'h0, dtr_n, rts_n}, 8'h00);
        br(1'b1, s);
        check(s, 8'h85);
        bw(1'b0, 8'ha5);
        br(1'b1, s);
        check(s & 8'h04, 8'h00);
        for (int i = 0; i < 50 && !transmitter_can_accept; i++) @(posedge clk_sys);
        bw(1'b0, 8'h3c);
        #1 check({7'h0, transmitter_can_accept}, 8'h00);
        for (int i = 0; i < 900 && term.n_got < 1; i++) @(posedge clk_sys);
        check(term.got, 8'ha5);
        for (int i = 0; i < 900 && term.n_got < 2; i++) @(posedge clk_sys);
        check(term.got, 8'h3c);
        for (int i = 0; i < 200 && !transmit_register_vacant; i++) @(posedge clk_sys);
        br(1'b1, s);
        check(s, 8'h85);
    endtask
    task automatic t_rx();
        logic [7:0] s;
        term.send({1'b1, 8'h3c, 1'b0}, 10, BITC);
        wait_st(1);
        check({7'h0, receive_char_waiting}, 8'h01);
        br(1'b0, s);
        check(s, 8'h3c);
        check({7'h0, receive_char_waiting}, 8'h00);
        term.send({1'b1, 8'h11, 1'b0}, 10, BITC);
        term.send({1'b1, 8'h22, 1'b0}, 10, BITC);
        br(1'b1, s);
        check(s & 8'h12, 8'h12);
        br(1'b0, s);
        check(s, 8'h22);
        term.send({1'b0, 8'h55, 1'b0}, 10, BITC);
        br(1'b1, s);
        check(s & 8'h22, 8'h22);
        bw(1'b1, 8'h37);
        br(1'b1, s);
        check(s & 8'h38, 8'h00);
    endtask
    task automatic t_parity();
        logic [7:0] s;
        init(8'h5e, 8'h00, 8'h27);
        term.send({2'b11, 8'h07, 1'b0}, 11, BITC);
        br(1'b1, s);
        check(s & 8'h0a, 8'h0a);
        br(1'b0, s);
        check(s, 8'h07);
        bw(1'b1, 8'h37);
        term.send({2'b10, 8'h07, 1'b0}, 11, BITC);
        br(1'b1, s);
        check(s & 8'h0a, 8'h02);
    endtask
    task automatic t_sync();
        logic [7:0] s;
        init(8'h8c, 8'h16, 8'h85);
        br(1'b1, s);
        check(s & 8'h40, 8'h00);
        term.send({4'h0, 8'h16}, 8, DIV);
        wait_st(6);
        br(1'b1, s);
        check(s & 8'h40, 8'h40);
        init(8'hcc, 8'h16, 8'h85);
        @(posedge clk_sys);
        ext_sync <= 1'b1;
        repeat (40) @(posedge clk_sys);
        ext_sync <= 1'b0;
        br(1'b1, s);
        check(s & 8'h42, 8'h02);
    endtask

    // =====
    // Clock, timeout, run
    task automatic summarize();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            summarize();
        end
    end

    initial begin
        rst = 1'b1;
        addr = 1'b0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        dsr_n = 1'b0;
        ext_sync = 1'b0;
        n_errors = 0;
        samples_checked = 0;
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_tx();
        t_rx();
        t_parity();
        t_sync();
        summarize();
    end
endmodule // board_serial_usart_interface_tb_top

`default_nettype wire
